// >>> cau_pkg.sv
package cau_pkg;
   localparam int CAU_NUM_IF = 2;
   localparam int CAU_AW = 32;
   localparam int CAU_DW = 32;
   localparam int CAU_RW = 16;
   localparam logic [31:0] CAU_IF1_UPPER_OFS = 32'h4005_0034;
   localparam logic [31:0] CAU_IF2_UPPER_OFS = 32'h4005_0094;
   localparam logic [15:0] CAU_UPPER_RST = 16'h0000;
   localparam logic [15:0] CAU_ZERO16 = 16'h0000;
   // field layout of the upper arbitration word
   localparam int CAU_TAG_MSB = 12;
   localparam int CAU_TAG_LSB = 0;
   localparam int CAU_STD_LSB = 2;
   localparam int CAU_DIR_BIT = 13;
   localparam int CAU_XTD_BIT = 14;
   localparam int CAU_VAL_BIT = 15;
   localparam int CAU_TAG_W = 13;

   // frame seen by the message handler, upper tag bits 28:16 only
   typedef struct packed {
      logic stb;
      logic remote;
      logic extended;
      logic [12:0] tag_hi;
   } cau_rx_t;

   // per-object decisions handed to the message handler
   typedef struct packed {
      logic send_remote;
      logic send_data;
      logic store_data;
      logic set_pending;
      logic tag_match;
   } cau_act_t;
endpackage

// >>> cau_arb_upper.sv
// Summary of operation
// - two interfaces each own an identical upper word at its own address
// - extended object: bits 12:0 hold tag bits 28 to 16
// - standard object: tag bits 28 to 18 used, bits 17:16 ignored
// - direction 0 with pending transmit sends a remote frame
// - direction 0: matching received data frame is stored in the object
// - direction 1 with pending transmit sends a data frame
// - direction 1: matching remote frame sets pending if answering enabled
// - width bit 0 selects the 11-bit standard tag
// - width bit 1 selects the 29-bit extended tag
// - valid bit 0: object ignored for sending and receiving
// - valid bit 1: object takes part in handler processing while init_active is low
// - pending 1 means transmit requested and not done, 0 means idle
// - remote frame sets pending only with answering enabled
module cau_arb_upper #(
   parameter int NUM_IF = cau_pkg::CAU_NUM_IF
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [cau_pkg::CAU_AW-1:0] bus_addr,
   input wire logic [cau_pkg::CAU_DW-1:0] bus_wdata,
   input wire logic bus_we,
   input wire logic bus_re,
   output logic [cau_pkg::CAU_DW-1:0] bus_rdata,
   input wire logic init_active,
   input wire logic [NUM_IF-1:0] transmit_pending,
   input wire logic [NUM_IF-1:0] remote_answer_enable,
   input wire cau_pkg::cau_rx_t rx_frame,
   output cau_pkg::cau_act_t [NUM_IF-1:0] obj_act,
   output logic [NUM_IF-1:0] object_valid,
   output logic [NUM_IF-1:0] long_tag_select
);

   logic [cau_pkg::CAU_RW-1:0] upper_reg [NUM_IF];
   logic [cau_pkg::CAU_RW-1:0] upper_next [NUM_IF];
   logic [cau_pkg::CAU_DW-1:0] rdata_reg;
   logic [cau_pkg::CAU_DW-1:0] rdata_next;
   cau_pkg::cau_act_t [NUM_IF-1:0] act_reg;
   cau_pkg::cau_act_t [NUM_IF-1:0] act_next;

   // one-hot select of an interface word; zero for unmapped addresses
   function automatic logic [NUM_IF-1:0] word_sel(
      input logic [cau_pkg::CAU_AW-1:0] a
   );
      logic [NUM_IF-1:0] s;
      s = '0;
      if (a == cau_pkg::CAU_IF1_UPPER_OFS) begin
         s[0] = 1'b1;
      end
      if (a == cau_pkg::CAU_IF2_UPPER_OFS) begin
         s[NUM_IF-1] = 1'b1;
      end
      return s;
   endfunction

   // width-aware compare of the upper tag bits
   function automatic logic tag_hit(
      input logic [cau_pkg::CAU_RW-1:0] w,
      input cau_pkg::cau_rx_t f
   );
      logic hit;
      hit = 1'b0;
      if (w[cau_pkg::CAU_XTD_BIT]) begin
         hit = f.extended && (f.tag_hi ==
            w[cau_pkg::CAU_TAG_MSB:cau_pkg::CAU_TAG_LSB]);
      end else begin
         hit = !f.extended &&
            (f.tag_hi[cau_pkg::CAU_TAG_MSB:cau_pkg::CAU_STD_LSB] ==
            w[cau_pkg::CAU_TAG_MSB:cau_pkg::CAU_STD_LSB]);
      end
      return hit;
   endfunction

   // register file
   always_comb begin
      logic [NUM_IF-1:0] wsel;
      logic [NUM_IF-1:0] rsel;
      wsel = word_sel(bus_addr);
      rsel = wsel;
      rdata_next = '0;
      for (int i = 0; i < NUM_IF; i++) begin
         upper_next[i] = upper_reg[i];
         if (bus_we && wsel[i]) begin
            upper_next[i] = bus_wdata[cau_pkg::CAU_RW-1:0];
         end
         if (bus_re && rsel[i]) begin
            rdata_next = {cau_pkg::CAU_ZERO16, upper_reg[i]};
         end
      end
   end

   // note: software keeps valid low while editing, so no write interlock
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_IF; i++) begin
            upper_reg[i] <= cau_pkg::CAU_UPPER_RST;
         end
         rdata_reg <= '0;
      end else begin
         for (int i = 0; i < NUM_IF; i++) begin
            upper_reg[i] <= upper_next[i];
         end
         rdata_reg <= rdata_next;
      end
   end

   // message handler decisions, nothing acts while init is held
   always_comb begin
      logic v;
      logic d;
      logic m;
      v = 1'b0;
      d = 1'b0;
      m = 1'b0;
      for (int i = 0; i < NUM_IF; i++) begin
         v = upper_reg[i][cau_pkg::CAU_VAL_BIT] && !init_active;
         d = upper_reg[i][cau_pkg::CAU_DIR_BIT];
         m = rx_frame.stb && tag_hit(upper_reg[i], rx_frame);
         act_next[i].tag_match = v && m;
         act_next[i].send_remote = v && !d && transmit_pending[i];
         act_next[i].send_data = v && d && transmit_pending[i];
         act_next[i].store_data = v && !d && m && !rx_frame.remote;
         act_next[i].set_pending = v && d && m && rx_frame.remote &&
            remote_answer_enable[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         act_reg <= '0;
      end else begin
         act_reg <= act_next;
      end
   end

   assign bus_rdata = rdata_reg;
   assign obj_act = act_reg;
   always_comb begin
      for (int i = 0; i < NUM_IF; i++) begin
         object_valid[i] = upper_reg[i][cau_pkg::CAU_VAL_BIT];
         long_tag_select[i] = upper_reg[i][cau_pkg::CAU_XTD_BIT];
      end
   end

   // checks
   localparam int RW = cau_pkg::CAU_RW;
   localparam int VB = cau_pkg::CAU_VAL_BIT;
   localparam int XB = cau_pkg::CAU_XTD_BIT;
   localparam int DB = cau_pkg::CAU_DIR_BIT;
   localparam int TM = cau_pkg::CAU_TAG_MSB;
   localparam int TL = cau_pkg::CAU_TAG_LSB;
   localparam int SL = cau_pkg::CAU_STD_LSB;
   localparam int LAST = NUM_IF - 1;
   localparam logic [cau_pkg::CAU_AW-1:0] A1 = cau_pkg::CAU_IF1_UPPER_OFS;
   localparam logic [cau_pkg::CAU_AW-1:0] A2 = cau_pkg::CAU_IF2_UPPER_OFS;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // bus strobe at one address
   sequence s_wr(logic [cau_pkg::CAU_AW-1:0] a);
      bus_we && bus_addr == a;
   endsequence

   sequence s_rd(logic [cau_pkg::CAU_AW-1:0] a);
      bus_re && bus_addr == a;
   endsequence

   // live object with a pending transmit and a given direction
   sequence s_tx_idle_obj(int i, logic dv);
      upper_reg[i][VB] && !init_active && transmit_pending[i] &&
      upper_reg[i][DB] == dv;
   endsequence

   // received frame hitting a live object, one sequence per width
   sequence s_ext_hit(int i);
      rx_frame.stb && upper_reg[i][VB] && !init_active &&
      upper_reg[i][XB] && rx_frame.extended &&
      rx_frame.tag_hi == upper_reg[i][TM:TL];
   endsequence

   sequence s_std_hit(int i);
      rx_frame.stb && upper_reg[i][VB] && !init_active &&
      !upper_reg[i][XB] && !rx_frame.extended &&
      rx_frame.tag_hi[TM:SL] == upper_reg[i][TM:SL];
   endsequence

   chk_if1_write: assert property (
      s_wr(A1) |=> upper_reg[0] == $past(bus_wdata[RW-1:0]))
      else $error("if1 upper word did not take write");

   chk_if2_write: assert property (
      s_wr(A2) |=> upper_reg[LAST] == $past(bus_wdata[RW-1:0]))
      else $error("if2 upper word did not take write");

   chk_if2_untouched: assert property (
      s_wr(A1) |=> upper_reg[LAST] == $past(upper_reg[LAST]))
      else $error("if1 write leaked into if2 word");

   chk_if1_untouched: assert property (
      s_wr(A2) |=> upper_reg[0] == $past(upper_reg[0]))
      else $error("if2 write leaked into if1 word");

   chk_stray_write: assert property (
      bus_we && bus_addr != A1 && bus_addr != A2 |=>
      upper_reg[0] == $past(upper_reg[0]) &&
      upper_reg[LAST] == $past(upper_reg[LAST]))
      else $error("unmapped write changed a word");

   chk_read_back: assert property (
      s_rd(A1) |=>
      bus_rdata == {cau_pkg::CAU_ZERO16, $past(upper_reg[0])})
      else $error("if1 read data wrong or high bits set");

   chk_if2_read_back: assert property (
      s_rd(A2) |=>
      bus_rdata == {cau_pkg::CAU_ZERO16, $past(upper_reg[LAST])})
      else $error("if2 read data wrong or high bits set");

   chk_stray_read: assert property (
      bus_re && bus_addr != A1 && bus_addr != A2 |=> bus_rdata == '0)
      else $error("unmapped read returned data");

   chk_rdata_idle: assert property (
      !bus_re |=> bus_rdata == '0)
      else $error("read data stood beyond its cycle");

   chk_reset_clear: assert property (
      @(posedge ref_clk) disable iff (1'b0)
      rst |=> upper_reg[0] == '0 && upper_reg[LAST] == '0 &&
      obj_act == '0 && bus_rdata == '0)
      else $error("fields not cleared by reset");

   chk_remote_send: assert property (
      s_tx_idle_obj(0, 1'b0) |=> obj_act[0].send_remote &&
      !obj_act[0].send_data)
      else $error("remote frame request missing");

   chk_if2_remote_send: assert property (
      s_tx_idle_obj(LAST, 1'b0) |=> obj_act[LAST].send_remote &&
      !obj_act[LAST].send_data)
      else $error("if2 remote frame request missing");

   chk_data_send: assert property (
      s_tx_idle_obj(0, 1'b1) |=> obj_act[0].send_data &&
      !obj_act[0].send_remote)
      else $error("data frame request missing");

   chk_if2_data_send: assert property (
      s_tx_idle_obj(LAST, 1'b1) |=> obj_act[LAST].send_data &&
      !obj_act[LAST].send_remote)
      else $error("if2 data frame request missing");

   chk_tx_quiet: assert property (
      !transmit_pending[0] |=> !obj_act[0].send_remote &&
      !obj_act[0].send_data)
      else $error("send requested with nothing pending");

   chk_if2_tx_quiet: assert property (
      !transmit_pending[LAST] |=> !obj_act[LAST].send_remote &&
      !obj_act[LAST].send_data)
      else $error("if2 send requested with nothing pending");

   chk_live_send: assert property (
      upper_reg[LAST][VB] && !init_active && transmit_pending[LAST] |=>
      obj_act[LAST].send_data || obj_act[LAST].send_remote)
      else $error("live object ignored by handler");

   chk_store_data: assert property (
      s_ext_hit(0) ##0 (!rx_frame.remote && !upper_reg[0][DB]) |=>
      obj_act[0].store_data)
      else $error("matching data frame not stored");

   chk_store_std: assert property (
      s_std_hit(0) ##0 (!rx_frame.remote && !upper_reg[0][DB]) |=>
      obj_act[0].store_data)
      else $error("standard data frame not stored");

   chk_if2_store_data: assert property (
      s_ext_hit(LAST) ##0 (!rx_frame.remote && !upper_reg[LAST][DB]) |=>
      obj_act[LAST].store_data)
      else $error("if2 matching data frame not stored");

   chk_no_store_remote: assert property (
      rx_frame.remote |=> !obj_act[0].store_data)
      else $error("remote frame stored as data");

   chk_if2_remote_kept: assert property (
      rx_frame.remote |=> !obj_act[LAST].store_data)
      else $error("if2 remote frame stored as data");

   chk_pend_set: assert property (
      s_ext_hit(0) ##0 (rx_frame.remote && upper_reg[0][DB] &&
      remote_answer_enable[0]) |=> obj_act[0].set_pending)
      else $error("remote frame did not set pending");

   chk_if2_pend_set: assert property (
      s_std_hit(LAST) ##0 (rx_frame.remote && upper_reg[LAST][DB] &&
      remote_answer_enable[LAST]) |=> obj_act[LAST].set_pending)
      else $error("if2 remote frame did not set pending");

   chk_pend_dir: assert property (
      !upper_reg[0][DB] |=> !obj_act[0].set_pending)
      else $error("receive object set pending");

   chk_if2_pend_dir: assert property (
      !upper_reg[LAST][DB] |=> !obj_act[LAST].set_pending)
      else $error("if2 receive object set pending");

   chk_pend_hold: assert property (
      !remote_answer_enable[0] |=> !obj_act[0].set_pending)
      else $error("pending set without remote answering");

   chk_if2_pend_hold: assert property (
      !remote_answer_enable[LAST] |=> !obj_act[LAST].set_pending)
      else $error("if2 pending set without remote answering");

   chk_ext_match: assert property (
      s_ext_hit(0) |=> obj_act[0].tag_match)
      else $error("extended tag match missed");

   chk_std_match: assert property (
      s_std_hit(0) |=> obj_act[0].tag_match)
      else $error("standard tag match missed");

   chk_if2_std_match: assert property (
      s_std_hit(LAST) |=> obj_act[LAST].tag_match)
      else $error("if2 standard tag match missed");

   chk_width_gate: assert property (
      rx_frame.extended != upper_reg[0][XB] |=> !obj_act[0].tag_match)
      else $error("match across tag widths");

   chk_if2_width_gate: assert property (
      rx_frame.extended != upper_reg[LAST][XB] |=>
      !obj_act[LAST].tag_match)
      else $error("if2 match across tag widths");

   chk_invalid_idle: assert property (
      !upper_reg[0][VB] |=> obj_act[0] == '0)
      else $error("invalid object produced action");

   chk_if2_invalid_idle: assert property (
      !upper_reg[LAST][VB] |=> obj_act[LAST] == '0)
      else $error("if2 invalid object produced action");

   chk_init_idle: assert property (
      init_active |=> obj_act == '0)
      else $error("action while controller in init");

endmodule // cau_arb_upper

// >>> cau_arb_upper_tb_top.sv
module cau_arb_upper_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A1 = cau_pkg::CAU_IF1_UPPER_OFS;
   localparam logic [31:0] A2 = cau_pkg::CAU_IF2_UPPER_OFS;
   logic ref_clk = 1'b0, rst = 1'b1, bus_we = 1'b0, bus_re = 1'b0;
   logic init_active = 1'b0, re_d = 1'b0, ac = 1'b0, ac_d = 1'b0;
   logic [31:0] bus_addr = 32'h0, bus_wdata = 32'h0, bus_rdata;
   logic [31:0] seed = 32'h0000_0037, d;
   logic [1:0] transmit_pending = 2'h0, remote_answer_enable = 2'h0;
   logic [1:0] object_valid, long_tag_select;
   cau_pkg::cau_rx_t rx_frame = '0, f;
   cau_pkg::cau_act_t [1:0] obj_act;
   logic [15:0] w [2] = '{16'h0, 16'h0};
   logic [31:0] rq [$];
   logic [13:0] aq [$];
   int fail_count = 0, n_checks = 0;

   always #5 ref_clk = ~ref_clk;

   cau_arb_upper u_dut (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
      .bus_rdata(bus_rdata), .init_active(init_active),
      .transmit_pending(transmit_pending),
      .remote_answer_enable(remote_answer_enable), .rx_frame(rx_frame),
      .obj_act(obj_act), .object_valid(object_valid),
      .long_tag_select(long_tag_select));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // expected handler decisions for one object
   function automatic cau_pkg::cau_act_t exp_act(logic [15:0] v, logic tp,
         logic rme, logic ini, cau_pkg::cau_rx_t x);
      cau_pkg::cau_act_t e;
      logic live, m;
      live = v[15] & ~ini;
      m = live & x.stb & (x.extended === v[14]) & (v[14] ?
         x.tag_hi === v[12:0] : x.tag_hi[12:2] === v[12:2]);
      e.send_remote = live & tp & ~v[13];
      e.send_data = live & tp & v[13];
      e.store_data = m & ~x.remote & ~v[13];
      e.set_pending = m & x.remote & v[13] & rme;
      e.tag_match = m;
      return e;
   endfunction

   task cmp_rd(logic [31:0] e, logic [31:0] s);
      n_checks++;
      if (s !== e) begin
         $display("[ERR] bus_rdata exp %h got %h", e, s);
         fail_count++;
      end
   endtask

   task cmp_act(logic [13:0] e, logic [13:0] s);
      n_checks++;
      if (s !== e) begin
         $display("[ERR] obj_act exp %h got %h", e, s);
         fail_count++;
      end
   endtask

   task wr(logic [31:0] a, logic [31:0] v);
      @(posedge ref_clk);
      bus_we <= 1'b1;
      bus_addr <= a;
      bus_wdata <= v;
      @(posedge ref_clk);
      bus_we <= 1'b0;
      if (a == A1) w[0] = v[15:0];
      if (a == A2) w[1] = v[15:0];
   endtask

   task rd(logic [31:0] a);
      @(posedge ref_clk);
      bus_re <= 1'b1;
      bus_addr <= a;
      rq.push_back(a == A1 ? {16'h0, w[0]} : a == A2 ? {16'h0, w[1]} : 32'h0);
      @(posedge ref_clk);
      bus_re <= 1'b0;
   endtask

   task act(logic [1:0] tp, logic [1:0] rme, logic ini, cau_pkg::cau_rx_t x);
      @(posedge ref_clk);
      transmit_pending <= tp;
      remote_answer_enable <= rme;
      init_active <= ini;
      rx_frame <= x;
      ac <= 1'b1;
      aq.push_back({exp_act(w[1], tp[1], rme[1], ini, x),
         exp_act(w[0], tp[0], rme[0], ini, x), w[1][15], w[0][15],
         w[1][14], w[0][14]});
      @(posedge ref_clk);
      ac <= 1'b0;
      rx_frame <= '0;
   endtask

   // results are matched against the oldest note, mid-cycle when settled
   always @(posedge ref_clk) begin
      re_d <= bus_re;
      ac_d <= ac;
   end
   always @(negedge ref_clk) begin
      if (re_d) cmp_rd(rq.pop_front(), bus_rdata);
      if (ac_d) cmp_act(aq.pop_front(), {obj_act, object_valid,
         long_tag_select});
   end

   task tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      init_active <= 1'b1;
      rd(A1);
      rd(A2);
      wr(32'h4005_0040, 32'hffff_ffff);
      rd(32'h4005_0040);
      rd(A1);
      // unused objects are parked invalid before init is left
      wr(A1, 32'h0);
      wr(A2, 32'h0);
      init_active <= 1'b0;
      $display("reset and unmapped test done");
      // tags reuse the stored word so matches happen often
      for (int i = 0; i < 60; i++) begin
         // valid drops before the fields are rewritten
         wr(A1, {16'h0, 1'h0, w[0][14:0]});
         wr(A2, {16'h0, 1'h0, w[1][14:0]});
         wr(A1, rnd());
         wr(A2, rnd());
         rd(A1);
         rd(A2);
         d = rnd();
         f.stb = d[16] | d[17];
         f.remote = d[0];
         f.extended = d[6] ? w[d[2]][14] : d[1];
         f.tag_hi = w[d[2]][12:0] ^ (d[3] ? {11'h0, d[5:4]} : 13'h0);
         act(d[9:8], d[11:10], d[12] & d[13] & d[14], f);
      end
      $display("random object test done");
      // reset in mid-run must clear words that hold data
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      w = '{16'h0, 16'h0};
      rd(A1);
      rd(A2);
      // let the last read reach the watcher before the verdict
      repeat (2) @(posedge ref_clk);
      $display("mid-run reset test done");
      tally_and_finish();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      tally_and_finish();
   end
endmodule // cau_arb_upper_tb_top
